// >>> rtl/ccio_pkg.sv
// Package for the clock conditioner input and output selection block.
// Assumes a single 200 MHz bus clock and an APB master outside.
//
// Behaviour
// - Three global outputs come from three muxes.
// - Each mux has source select, output mux, delay.
// - Core outputs mirror secondary globals, longer delay.
// - Core outputs enable independently of their globals.
// - Enabled outputs follow one of three groupings.
// - Up to three frequencies from one reference.
// - Five separate output phase delays.
// - Feedback delay advances outputs against reference.
// - Reference from global pad, core, or routed tap.
// - Power-up outputs toggle while reference is stuck.
// - Sleep asserted forces every output low.
// - Single-ended pads: first, second or third.
// - Differential pairs: pads one+two, three+regular.
// - Mux tree picks pad set or internal clock.
// - Three single, two differential, or fabric sources.
// - Unused global pads act as regular I/O.
// - Delay-only path may use any of nine pads.
// - PLL path uses only the three A pads.
// - Routed regular input adds delay over hardwired.
// - Differential sources only on large parts.
// - Source: pad, routed input, core, optional oscillators.

package ccio_pkg;

  // --------------------------------------------------------------------
  // Register map (byte offsets on APB).
  // --------------------------------------------------------------------
  localparam logic [11:0] CCIO_OFF_SRC = 12'h000;
  localparam logic [11:0] CCIO_OFF_OUT = 12'h004;
  localparam logic [11:0] CCIO_OFF_DLY_A = 12'h008;
  localparam logic [11:0] CCIO_OFF_DLY_B = 12'h00C;
  localparam logic [11:0] CCIO_OFF_DLY_C = 12'h010;
  localparam logic [11:0] CCIO_OFF_DLY_CF = 12'h014;
  localparam logic [11:0] CCIO_OFF_DLY_CS = 12'h018;
  localparam logic [11:0] CCIO_OFF_FB = 12'h01C;
  localparam logic [11:0] CCIO_OFF_STATUS = 12'h020;

  // --------------------------------------------------------------------
  // Field widths and positions.
  // --------------------------------------------------------------------
  localparam int CCIO_DLY_W = 5;       // Global output delay taps.
  localparam int CCIO_YDLY_W = 6;      // Core output delay taps, wider.
  localparam int CCIO_DIV_W = 8;       // Output divider ratios.
  localparam int CCIO_PAD_W = 9;       // Nine dedicated pad slots.

  // Source register layout.
  localparam int CCIO_SRC_KIND_LSB = 0;   // Two bits: source kind.
  localparam int CCIO_SRC_DIFF_BIT = 2;   // Differential standard.
  localparam int CCIO_SRC_PAD_LSB = 4;    // Four bits: pad slot index.
  localparam int CCIO_SRC_PLL_BIT = 8;    // PLL core used.
  localparam int CCIO_SRC_BIG_BIT = 9;    // Part allows differential.
  localparam int CCIO_SRC_OSC_BIT = 10;   // Variant has oscillators.

  // Output register layout.
  localparam int CCIO_OUT_GB_BIT = 0;
  localparam int CCIO_OUT_CF_BIT = 1;
  localparam int CCIO_OUT_GC_BIT = 2;
  localparam int CCIO_OUT_CS_BIT = 3;
  localparam int CCIO_OUT_RUN_BIT = 4;    // Software run enable.
  localparam int CCIO_OUT_DIVA_LSB = 8;
  localparam int CCIO_OUT_DIVB_LSB = 16;
  localparam int CCIO_OUT_DIVC_LSB = 24;

  // --------------------------------------------------------------------
  // Reset values.
  // --------------------------------------------------------------------
  localparam logic [31:0] CCIO_RST_SRC = 32'h0000_0000;
  localparam logic [31:0] CCIO_RST_OUT = 32'h0000_0000;
  localparam logic [7:0] CCIO_RST_DIV = 8'h00;

  // --------------------------------------------------------------------
  // Timing: power-up free-run toggle between 40 and 250 MHz.
  // --------------------------------------------------------------------
  localparam int CCIO_CLK_MHZ = 200;
  localparam int CCIO_FREE_MHZ = 40;
  // Half period of the free-run toggle, in bus cycles, rounded down.
  localparam int CCIO_FREE_HALF = CCIO_CLK_MHZ / (2 * CCIO_FREE_MHZ);
  // Reference considered stuck after this many bus cycles of no edge.
  localparam int CCIO_STUCK_CYC = 64;

  // --------------------------------------------------------------------
  // Enumerations.
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCIO_SRC_PAD = 2'b00,     // Hardwired dedicated global pad.
    CCIO_SRC_ROUTED = 2'b01,  // Regular input over the routed tap.
    CCIO_SRC_CORE = 2'b10,    // Core logic signal.
    CCIO_SRC_OSC = 2'b11      // Internal RC or crystal oscillator.
  } ccio_src_e;

  typedef enum logic [1:0] {
    CCIO_GRP_ONE = 2'b00,
    CCIO_GRP_TWO = 2'b01,
    CCIO_GRP_THREE = 2'b10,
    CCIO_GRP_BAD = 2'b11
  } ccio_grp_e;

  typedef enum logic [1:0] {
    CCIO_ST_SLEEP = 2'b00,
    CCIO_ST_FREE = 2'b01,
    CCIO_ST_LOCKED = 2'b10
  } ccio_state_e;

  // Five clock outputs travel together.
  typedef struct packed {
    logic primary_global_clk;
    logic secondary1_global_clk;
    logic secondary2_global_clk;
    logic core_clk_first;
    logic core_clk_second;
  } ccio_clks_s;

endpackage : ccio_pkg

// >>> rtl/ccio_top.sv
// Clock conditioner selection and output logic, modelled at bus rate.
// Assumes pad and core clock inputs are slow and synchronous to pclk.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ccio_top
  import ccio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CCIO_PAD_W-1:0] global_pad_in,
  input wire logic regular_input_buffer,
  input wire logic core_clk_src,
  input wire logic osc_clk_in,
  input wire logic pll_sleep_n,
  output ccio_clks_s clks,
  output logic pll_locked,
  output logic [CCIO_PAD_W-1:0] pad_as_regular_io
);

  // --------------------------------------------------------------------
  // Configuration registers.
  // --------------------------------------------------------------------
  logic [31:0] src_q, src_d;           // Source selection.
  logic [31:0] out_q, out_d;           // Output enables and dividers.
  logic [CCIO_DLY_W-1:0] dly_q [3], dly_d [3];    // Global delays.
  logic [CCIO_YDLY_W-1:0] ydly_q [2], ydly_d [2]; // Core delays.
  logic [CCIO_DLY_W-1:0] fb_q, fb_d;   // Feedback advance.
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic wr_cfg_err;                    // Write refused while running.

  // Field views.
  ccio_src_e src_kind;
  logic src_diff, src_pll, src_big, src_osc_ok;
  logic [3:0] pad_idx;
  assign src_kind = ccio_src_e'(src_q[CCIO_SRC_KIND_LSB +: 2]);
  assign src_diff = src_q[CCIO_SRC_DIFF_BIT];
  assign pad_idx = src_q[CCIO_SRC_PAD_LSB +: 4];
  assign src_pll = src_q[CCIO_SRC_PLL_BIT];
  assign src_big = src_q[CCIO_SRC_BIG_BIT];
  assign src_osc_ok = src_q[CCIO_SRC_OSC_BIT];

  logic run;
  assign run = out_q[CCIO_OUT_RUN_BIT];

  // --------------------------------------------------------------------
  // Pad legality and reference mux tree.
  // --------------------------------------------------------------------
  logic cfg_ok;       // Current selection is a legal one.
  logic ref_sel;      // Selected reference level.
  logic [CCIO_PAD_W-1:0] pad_claim;

  // Legality of the pad choice; an illegal choice keeps outputs low.
  always_comb begin
    cfg_ok = 1'b1;
    pad_claim = '0;
    ref_sel = 1'b0;
    case (src_kind)
      CCIO_SRC_PAD: begin
        if (pad_idx > 4'd8) begin
          cfg_ok = 1'b0;
        end else if (src_pll && pad_idx > 4'd2) begin
          cfg_ok = 1'b0;
        end else if (src_diff) begin
          // Pads pair within a group: slot 0 with 1, slot 2 with regular.
          if (!src_big) begin
            cfg_ok = 1'b0;
          end else if (pad_idx % 4'd3 == 4'd1) begin
            cfg_ok = 1'b0;
          end
        end
        if (cfg_ok) begin
          pad_claim[pad_idx] = 1'b1;
          if (src_diff && pad_idx % 4'd3 == 4'd0) begin
            pad_claim[pad_idx + 4'd1] = 1'b1;
          end
          ref_sel = global_pad_in[pad_idx];
        end
      end
      CCIO_SRC_ROUTED: begin
        ref_sel = regular_input_buffer;
      end
      CCIO_SRC_CORE: begin
        ref_sel = core_clk_src;
      end
      CCIO_SRC_OSC: begin
        cfg_ok = src_osc_ok;
        ref_sel = src_osc_ok & osc_clk_in;
      end
      default: begin
        cfg_ok = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Routed path delay stage and reference edge tracking.
  // --------------------------------------------------------------------
  logic ref_q, ref_d;       // Reference after path delay.
  logic routed_q, routed_d; // Extra stage for the routed input.
  logic [6:0] idle_q, idle_d;
  logic ref_rise;

  // The routed regular input gets one extra register stage: slower path.
  always_comb begin
    routed_d = ref_sel;
    ref_d = (src_kind == CCIO_SRC_ROUTED) ? routed_q : ref_sel;
    idle_d = idle_q;
    if (ref_d != ref_q) begin
      idle_d = '0;
    end else if (idle_q != 7'(CCIO_STUCK_CYC)) begin
      idle_d = idle_q + 7'd1;
    end
  end
  assign ref_rise = ref_d & ~ref_q;

  // --------------------------------------------------------------------
  // Output generation: three shared dividers, per-output phase delay.
  // --------------------------------------------------------------------
  ccio_state_e st_q, st_d;
  logic locked_q; // Lock flag, kept in a flop so the pin is glitch free.
  logic [CCIO_DIV_W-1:0] div_cnt_q [3], div_cnt_d [3];
  logic [2:0] div_clk_q, div_clk_d;    // Up to three different frequencies.
  logic [3:0] free_cnt_q, free_cnt_d;
  logic free_clk_q, free_clk_d;
  logic [63:0] tap_q [5], tap_d [5];   // Phase delay lines.
  logic [4:0] en;                      // Grouped enables.
  ccio_clks_s clks_q, clks_d;
  logic [4:0] raw;
  logic [4:0] dly_out;

  // Grouping check: no secondary-2 without secondary-1 pair.
  always_comb begin
    en = 5'b00001;
    if (out_q[CCIO_OUT_GB_BIT] | out_q[CCIO_OUT_CF_BIT]) begin
      en[1] = out_q[CCIO_OUT_GB_BIT];
      en[3] = out_q[CCIO_OUT_CF_BIT];
      en[2] = out_q[CCIO_OUT_GC_BIT];
      en[4] = out_q[CCIO_OUT_CS_BIT];
    end
  end

  // State: sleep forces low, free-run while reference stuck, else lock.
  always_comb begin
    st_d = st_q;
    if (!pll_sleep_n || !run || !cfg_ok) begin
      st_d = CCIO_ST_SLEEP;
    end else if (idle_q == 7'(CCIO_STUCK_CYC)) begin
      st_d = CCIO_ST_FREE;
    end else begin
      st_d = CCIO_ST_LOCKED;
    end
  end

  // Dividers count reference rising edges; divide by 2*(ratio+1).
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      div_cnt_d[i] = div_cnt_q[i];
      div_clk_d[i] = div_clk_q[i];
      if (st_q != CCIO_ST_LOCKED) begin
        div_cnt_d[i] = '0;
        div_clk_d[i] = 1'b0;
      end else if (ref_rise) begin
        if (div_cnt_q[i] == out_q[CCIO_OUT_DIVA_LSB + 8*i +: 8]) begin
          div_cnt_d[i] = '0;
          div_clk_d[i] = ~div_clk_q[i];
        end else begin
          div_cnt_d[i] = div_cnt_q[i] + 8'd1;
        end
      end
    end
    free_cnt_d = free_cnt_q + 4'd1;
    free_clk_d = free_clk_q;
    if (free_cnt_q == 4'(CCIO_FREE_HALF - 1)) begin
      free_cnt_d = '0;
      free_clk_d = ~free_clk_q;
    end
  end

  // Each output's source: core twins copy the secondary dividers.
  always_comb begin
    raw = {div_clk_q[2], div_clk_q[1], div_clk_q[2], div_clk_q[1],
           div_clk_q[0]};
    if (st_q == CCIO_ST_FREE) begin
      raw = {5{free_clk_q}};
    end
    for (int k = 0; k < 5; k++) begin
      tap_d[k] = {tap_q[k][62:0], raw[k]};
    end
    // Feedback advance shortens every line by the same amount.
    dly_out[0] = tap_q[0][6'(CCIO_DLY_W'(dly_q[0] - fb_q))];
    dly_out[1] = tap_q[1][6'(CCIO_DLY_W'(dly_q[1] - fb_q))];
    dly_out[2] = tap_q[2][6'(CCIO_DLY_W'(dly_q[2] - fb_q))];
    dly_out[3] = tap_q[3][ydly_q[0] - 6'(fb_q)];
    dly_out[4] = tap_q[4][ydly_q[1] - 6'(fb_q)];
    clks_d = '0;
    if (st_q != CCIO_ST_SLEEP && pll_sleep_n) begin
      clks_d.primary_global_clk = dly_out[0] & en[0];
      clks_d.secondary1_global_clk = dly_out[1] & en[1];
      clks_d.secondary2_global_clk = dly_out[2] & en[2];
      clks_d.core_clk_first = dly_out[3] & en[3];
      clks_d.core_clk_second = dly_out[4] & en[4];
    end
  end

  // --------------------------------------------------------------------
  // APB slave: zero-wait, registered answer.
  // --------------------------------------------------------------------
  // Config writes are refused while running so clocks never glitch.
  assign wr_cfg_err = run && (paddr != CCIO_OFF_OUT);

  always_comb begin
    src_d = src_q;
    out_d = out_q;
    dly_d = dly_q;
    ydly_d = ydly_q;
    fb_d = fb_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      pready_d = 1'b1;
      prdata_d = '0;
      if (pwrite) begin
        if (wr_cfg_err) begin
          pslverr_d = 1'b1;
        end else begin
          case (paddr)
            CCIO_OFF_SRC: src_d = {21'h0, pwdata[10:0]};
            CCIO_OFF_OUT: begin
              // Only the run bit may change while running.
              if (run) begin
                out_d[CCIO_OUT_RUN_BIT] = pwdata[CCIO_OUT_RUN_BIT];
              end else begin
                out_d = pwdata;
              end
            end
            CCIO_OFF_DLY_A: dly_d[0] = pwdata[CCIO_DLY_W-1:0];
            CCIO_OFF_DLY_B: dly_d[1] = pwdata[CCIO_DLY_W-1:0];
            CCIO_OFF_DLY_C: dly_d[2] = pwdata[CCIO_DLY_W-1:0];
            CCIO_OFF_DLY_CF: ydly_d[0] = pwdata[CCIO_YDLY_W-1:0];
            CCIO_OFF_DLY_CS: ydly_d[1] = pwdata[CCIO_YDLY_W-1:0];
            CCIO_OFF_FB: fb_d = pwdata[CCIO_DLY_W-1:0];
            default: pslverr_d = 1'b1;
          endcase
        end
      end else begin
        case (paddr)
          CCIO_OFF_SRC: prdata_d = src_q;
          CCIO_OFF_OUT: prdata_d = out_q;
          CCIO_OFF_DLY_A: prdata_d = 32'(dly_q[0]);
          CCIO_OFF_DLY_B: prdata_d = 32'(dly_q[1]);
          CCIO_OFF_DLY_C: prdata_d = 32'(dly_q[2]);
          CCIO_OFF_DLY_CF: prdata_d = 32'(ydly_q[0]);
          CCIO_OFF_DLY_CS: prdata_d = 32'(ydly_q[1]);
          CCIO_OFF_FB: prdata_d = 32'(fb_q);
          CCIO_OFF_STATUS: prdata_d = {27'h0, en[4:1], cfg_ok} |
                                      {24'h0, 6'h0, st_q} << 5;
          default: pslverr_d = 1'b1;
        endcase
      end
    end else if (psel && penable) begin
      pready_d = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // All registers.
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= CCIO_RST_SRC;
      out_q <= CCIO_RST_OUT;
      dly_q <= '{default: '0};
      ydly_q <= '{default: '0};
      fb_q <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      ref_q <= 1'b0;
      routed_q <= 1'b0;
      idle_q <= '0;
      st_q <= CCIO_ST_SLEEP;
      locked_q <= 1'b0;
      div_cnt_q <= '{default: CCIO_RST_DIV};
      div_clk_q <= '0;
      free_cnt_q <= '0;
      free_clk_q <= 1'b0;
      tap_q <= '{default: '0};
      clks_q <= '0;
      pad_as_regular_io <= '1;
    end else begin
      src_q <= src_d;
      out_q <= out_d;
      dly_q <= dly_d;
      ydly_q <= ydly_d;
      fb_q <= fb_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      ref_q <= ref_d;
      routed_q <= routed_d;
      idle_q <= idle_d;
      st_q <= st_d;
      locked_q <= (st_d == CCIO_ST_LOCKED);
      div_cnt_q <= div_cnt_d;
      div_clk_q <= div_clk_d;
      free_cnt_q <= free_cnt_d;
      free_clk_q <= free_clk_d;
      tap_q <= tap_d;
      clks_q <= clks_d;
      pad_as_regular_io <= ~pad_claim;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign clks = clks_q;
  assign pll_locked = locked_q;

endmodule : ccio_top

`default_nettype wire

// >>> verif/ccio_properties.sv
// Concurrent checks for the clock conditioner selection block.
// Sees only the top module ports; bound to ccio_top at the foot.
`timescale 1ns/1ps
`default_nettype none

module ccio_properties
  import ccio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pll_sleep_n,
  input wire ccio_clks_s clks,
  input wire logic pll_locked
);
  // ----------------------------------------
  // One clock domain, so one default each.
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Setup is answered in the very next cycle, with no wait states.
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("setup not answered next cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  // Pulse only: a stuck ready would end two transfers at once.
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held for two cycles");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  unmapped_err_a: assert property (
    psel && !penable && paddr > 12'h020 |=> pslverr)
    else $error("unmapped address not refused");
  // Two sampled cycles allow for the output register stage.
  sleep_quiet_a: assert property (!pll_sleep_n [*2] |-> clks == '0)
    else $error("clock output active during sleep");
  sleep_unlock_a: assert property (
    !pll_sleep_n [*2] |-> !pll_locked)
    else $error("lock shown during sleep");
  wake_quiet_a: assert property (
    !pll_sleep_n [*2] ##1 pll_sleep_n |-> clks == '0)
    else $error("clock output active at wake edge");

  // ----------------------------------------
  // Scenarios worth seeing.
  // ----------------------------------------
  cover property (pslverr);
  cover property (!pll_sleep_n ##1 pll_sleep_n);
  cover property ($rose(clks.primary_global_clk));

endmodule : ccio_properties

bind ccio_top ccio_properties ccio_properties_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .pll_sleep_n(pll_sleep_n),
  .clks(clks),
  .pll_locked(pll_locked)
);

`default_nettype wire

// >>> verif/ccio_ref_model.sv
// Far side model: clock pads, routed input, core and oscillator sources.
// Assumes the bench starts the reference and allows wake-up.
`timescale 1ns/1ps
`default_nettype none

module ccio_ref_model
  import ccio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_run,
  input wire logic [3:0] ref_slot,
  input wire logic wake,
  output logic [CCIO_PAD_W-1:0] global_pad_in,
  output logic regular_input_buffer,
  output logic core_clk_src,
  output logic osc_clk_in,
  output logic pll_sleep_n
);
  logic [2:0] cnt_q, cnt_d;  // Half period counter.
  logic ref_q, ref_d;  // Reference level, held when stopped.
  logic seen_q, seen_d;  // Reference has toggled at least once.
  logic [8:0] noise_q, noise_d;  // Unused pads never hold a level.

  // ----------------------------------------
  // Reference generator, half period of four cycles.
  // ----------------------------------------
  always_comb begin
    cnt_d = ref_run ? cnt_q + 3'h1 : 3'h0;
    ref_d = ref_q;
    seen_d = seen_q;
    if (ref_run && cnt_q == 3'h3) begin
      ref_d = ~ref_q;
      cnt_d = 3'h0;
      seen_d = 1'b1;
    end
    noise_d = {noise_q[7:0], noise_q[8] ^ noise_q[4]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      ref_q <= 1'b0;
      seen_q <= 1'b0;
      noise_q <= 9'h1A5;
    end else begin
      cnt_q <= cnt_d;
      ref_q <= ref_d;
      seen_q <= seen_d;
      noise_q <= noise_d;
    end
  end

  // Chosen pad carries the reference; the others show a moving pattern.
  always_comb begin
    global_pad_in = noise_q;
    global_pad_in[ref_slot] = ref_q;
  end
  assign regular_input_buffer = ref_q;
  assign core_clk_src = ref_q;
  assign osc_clk_in = ref_q;
  // Sleep is held until the reference has run, so no power-up toggling.
  assign pll_sleep_n = wake && seen_q;

endmodule : ccio_ref_model

`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the clock conditioner selection block.
// Assumes the reference model drives pads, sources and sleep.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ccio_pkg::*;

  // ----------------------------------------
  // Signals and counters.
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, pll_locked, pll_sleep_n;
  logic [CCIO_PAD_W-1:0] global_pad_in, pad_as_regular_io;
  logic regular_input_buffer, core_clk_src, osc_clk_in;
  ccio_clks_s clks, clks_prev;
  logic [4:0] seen = 5'h00;  // Outputs that moved since the last clear.
  logic ref_run = 1'b0, wake = 1'b0, tog_clr = 1'b0;
  int errors = 0, num_checks = 0, seed = 41, cyc = 0;
  // Corner sources: PLL pads, slot limits, pairing, oscillators.
  logic [31:0] tbl [12] = '{32'h100, 32'h130, 32'h080, 32'h090,
    32'h004, 32'h204, 32'h214, 32'h224, 32'h003, 32'h403, 32'h001, 32'h002};

  always #2.5 pclk = ~pclk;

  ccio_top ccio_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_pad_in(global_pad_in),
    .regular_input_buffer(regular_input_buffer),
    .core_clk_src(core_clk_src), .osc_clk_in(osc_clk_in),
    .pll_sleep_n(pll_sleep_n), .clks(clks), .pll_locked(pll_locked),
    .pad_as_regular_io(pad_as_regular_io));

  ccio_ref_model ccio_ref_model_inst (.pclk(pclk), .presetn(presetn),
    .ref_run(ref_run), .ref_slot(4'h0), .wake(wake),
    .global_pad_in(global_pad_in),
    .regular_input_buffer(regular_input_buffer),
    .core_clk_src(core_clk_src), .osc_clk_in(osc_clk_in),
    .pll_sleep_n(pll_sleep_n));

  // Activity monitor and run limit; the limit is far above the plan.
  always @(posedge pclk) begin
    clks_prev <= clks;
    seen <= tog_clr ? 5'h00 : seen | (clks ^ clks_prev);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // Checking and bus tasks.
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // One transfer; leaves the bus in access so a setup may follow at once.
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
  endtask : apb

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp({31'h0, e}, {31'h0, ee});
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] x, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r & m, x);
    cmp({31'h0, e}, {31'h0, ee});
  endtask : rdc

  // Clears the monitor, lets the clocks run, then checks which moved.
  task automatic watch(input logic [4:0] m);
    tog_clr <= 1'b1;
    @(posedge pclk);
    tog_clr <= 1'b0;
    repeat (300) @(posedge pclk);
    cmp({27'h0, seen & m}, {27'h0, m});
  endtask : watch

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Expected values.
  // ----------------------------------------
  function automatic logic [31:0] exp_ok(input logic [31:0] s);
    logic [3:0] p;
    p = s[7:4];
    if (s[1:0] == 2'h3) return {31'h0, s[10]};
    if (s[1:0] != 2'h0) return 32'h1;
    if (p > 4'h8 || (s[8] && p > 4'h2)) return 32'h0;
    if (s[2] && (!s[9] || p % 3 == 1)) return 32'h0;
    return 32'h1;
  endfunction : exp_ok

  // Slot zero of a group pairs with slot one; slot two with a plain pin.
  function automatic logic [31:0] exp_pads(input logic [31:0] s);
    logic [31:0] u;
    u = 32'h0;
    if (s[1:0] == 2'h0) u = (s[2] && s[7:4] % 3 == 0) ?
      32'h3 << s[7:4] : 32'h1 << s[7:4];
    return ~u & 32'h1FF;
  endfunction : exp_pads

  // Second secondary pair counts only beside a first secondary.
  // Status order, high to low: core second, core first, sec2, sec1.
  function automatic logic [31:0] exp_eff(input logic [3:0] o);
    return {27'h0, o[3] & |o[1:0], o[1], o[2] & |o[1:0], o[0], 1'b0};
  endfunction : exp_eff

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    logic [31:0] s, m;
    logic [11:0] a;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CCIO_OFF_SRC, 32'hFFFF_FFFF, CCIO_RST_SRC, 1'b0);
    rdc(CCIO_OFF_OUT, 32'hFFFF_FFFF, CCIO_RST_OUT, 1'b0);
    cmp({23'h0, pad_as_regular_io}, exp_pads(CCIO_RST_SRC));
    for (int i = 0; i < 4; i++) begin
      a = 12'h024 + 12'(4 * ($random(seed) & 63));
      rdc(a, 32'h0, 32'h0, 1'b1);
    end
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) begin
      a = CCIO_OFF_DLY_A + 12'(4 * i);
      m = (32'h1 << (i < 3 || i == 5 ? CCIO_DLY_W : CCIO_YDLY_W)) - 32'h1;
      s = $random(seed);
      wr(a, s, 1'b0);
      rdc(a, m, s & m, 1'b0);
    end
    $display("test delays done");
    for (int i = 0; i < 16; i++) begin
      wr(CCIO_OFF_OUT, 32'(i), 1'b0);
      rdc(CCIO_OFF_STATUS, 32'h1E, exp_eff(4'(i)), 1'b0);
    end
    $display("test groupings done");
    for (int i = 0; i < 42; i++) begin
      s = (i < 12) ? tbl[i] : $random(seed) & 32'h7FF;
      if (s[1:0] != 2'h0) s[7:2] = 6'h00;
      wr(CCIO_OFF_SRC, s, 1'b0);
      rdc(CCIO_OFF_STATUS, 32'h1, exp_ok(s), 1'b0);
      if (exp_ok(s) == 32'h1)
        cmp({23'h0, pad_as_regular_io}, exp_pads(s));
    end
    $display("test sources done");
    wr(CCIO_OFF_SRC, 32'h0000_0100, 1'b0);
    wr(CCIO_OFF_OUT, 32'h0000_001F, 1'b0);
    wr(CCIO_OFF_SRC, 32'h0000_0000, 1'b1);
    rdc(CCIO_OFF_SRC, 32'hFFFF_FFFF, 32'h0000_0100, 1'b0);
    idle();
    ref_run <= 1'b1;
    wake <= 1'b1;
    watch(5'h1F);
    cmp({31'h0, pll_locked}, 32'h1);
    wake <= 1'b0;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      cmp({26'h0, clks, pll_locked}, 32'h0);
    end
    wake <= 1'b1;
    ref_run <= 1'b0;
    repeat (80) @(posedge pclk);
    watch(5'h10);
    rdc(CCIO_OFF_STATUS, 32'h60, 32'h20, 1'b0);
    $display("test run and sleep done");
    conclude();
  end

endmodule : testbench

`default_nettype wire
